//--- src/line_imager_consts.svh
/*
  Constants for the line imager configuration register bank: byte offsets,
  field positions and reset values.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef LINE_IMAGER_CONSTS_SVH
`define LINE_IMAGER_CONSTS_SVH

// ****************************************************************************
// Register byte offsets
// ****************************************************************************
`define OFS_IMAGER_CONTROL      8'h00
`define OFS_VIDEO_BANDWIDTH     8'h01
`define OFS_MISC_SETTINGS       8'h02
`define OFS_OSC_FINE_TRIM       8'h90
`define OFS_BW_NOISE_SELECT     8'h94
`define OFS_LEFT_TEMP_LOW       8'hA0
`define OFS_LEFT_TEMP_HIGH      8'hA1
`define OFS_RIGHT_TEMP_LOW      8'hA2
`define OFS_RIGHT_TEMP_HIGH     8'hA3
`define OFS_TEMP_SETUP          8'hA4
`define OFS_BUS_ERROR_FLAG      8'hB0
`define OFS_ANALOG_OVERRIDE     8'hD6
`define OFS_OSC_COARSE_TRIM     8'hD7
`define OFS_SILICON_REVISION    8'hFF

// ****************************************************************************
// Reset values
// ****************************************************************************
`define RST_IMAGER_CONTROL      8'h14
`define RST_VIDEO_BANDWIDTH     8'h05
`define RST_MISC_SETTINGS       8'h98
`define RST_OSC_FINE_TRIM       8'h00
`define RST_BW_NOISE_SELECT     8'h03
`define RST_TEMP_SETUP          8'h00
`define RST_ANALOG_OVERRIDE     8'h20
`define RST_OSC_COARSE_TRIM     8'h00

// ****************************************************************************
// Field positions and codes
// ****************************************************************************
`define BIT_READ_DIRECTION      0
`define BIT_VARIANT_READOUT     1
`define GAIN_LSB                2
`define MODE_LSB                4
`define BIT_CONFIG_SOURCE       0
`define GAIN_CODE_TWO           2'h0
`define GAIN_CODE_ONE           2'h1
`define GAIN_CODE_FOUR          2'h2
`define BW_CODE_1MHZ            4'hA
`define BW_CODE_4MHZ            4'h8
`define BW_CODE_8MHZ            4'h2
`define BW_CODE_16MHZ           4'h5
`define NUM_REGS                14

`endif

//--- src/line_imager_pkg.sv
/*
  Types for the line imager configuration register bank.
  Assumes line_imager_consts.svh is on the include path.
*/
package line_imager_pkg;
  `include "line_imager_consts.svh"

  // Register access request from the two-wire slave front end.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Effective imager settings driven to the analog core.
  typedef struct packed {
    logic [1:0] output_mode_field;
    logic [1:0] gain_code;
    logic       variant_readout_bit;
    logic       read_direction;
    logic [3:0] bandwidth_code;
    logic [1:0] bandwidth_scale_select;
  } imager_cfg_s;

  // Pin derived settings used while pins are the configuration source.
  typedef struct packed {
    logic [1:0] gain_code;
    logic       read_direction;
    logic [3:0] bandwidth_code;
  } pin_cfg_s;
endpackage : line_imager_pkg

//--- src/line_imager_bank.sv
/*
  Small register storage for the fourteen byte registers, indexed by slot,
  with registered read data.
  Assumes a single clock and an active low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
// Reset values and the slot count come from the shared constants header.
`include "line_imager_consts.svh"
module line_imager_bank (
  // Clock and reset.
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  // Write port.
  input  wire logic        we_in,
  input  wire logic [3:0]  wslot_in,
  input  wire logic [7:0]  wdata_in,
  // Read port.
  input  wire logic [3:0]  rslot_in,
  input  wire logic [7:0]  ext_in [0:13],
  output logic      [7:0]  rdata_out,
  // Whole storage, for the control logic.
  output logic      [7:0]  store_out [0:13]
);
  import line_imager_pkg::*;

  // Reset value for each slot; read only slots reset to zero.
  localparam logic [7:0] RESET_VAL [0:13] = '{`RST_IMAGER_CONTROL,
    `RST_VIDEO_BANDWIDTH, `RST_MISC_SETTINGS, `RST_OSC_FINE_TRIM,
    `RST_BW_NOISE_SELECT, 8'h00, 8'h00, 8'h00, 8'h00, `RST_TEMP_SETUP,
    8'h00, `RST_ANALOG_OVERRIDE, `RST_OSC_COARSE_TRIM, 8'h00};
  // Slots whose storage software may write.
  localparam logic [13:0] WRITABLE = 14'b01_1010_0001_1111;

  // ****************************************************************************
  // Storage, one flop group per slot
  // ****************************************************************************
  genvar g;
  generate
    for (g = 0; g < `NUM_REGS; g++) begin : g_slot
      // Each slot returns to its factory value on reset.
      always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          store_out[g] <= RESET_VAL[g]; // see RULE3
        end else if (WRITABLE[g]) begin
          if (we_in && wslot_in == 4'(g)) begin
            store_out[g] <= wdata_in;
          end
        end else begin
          store_out[g] <= ext_in[g];
        end
      end
    end
  endgenerate

  // Read data leave from a register.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= (rslot_in < 4'(`NUM_REGS)) ? store_out[rslot_in] : 8'h00;
    end
  end
endmodule : line_imager_bank
`default_nettype wire

//--- src/line_imager_config_regs.sv
/*
  Configuration register bank of a line imager, reached through a byte wide
  register port fed by the two-wire slave front end.
  Assumes the front end delivers one-cycle write and read strobes synchronous
  to clock_in, and that the read pulse is a plain synchronous input.
*/
// Summary of operation
// RULE1: Decode fourteen byte addresses, 0x00 to 0xFF.
// RULE2: Master never writes undecoded addresses.
// RULE3: Reset restores every register to factory values.
// RULE4: Master writes back untouched not-applicable bits.
// RULE5: Gain from control bits 3:2.
// RULE6: Control bit 0 sets pixel readout order.
// RULE7: Master programs output mode per variant.
// RULE8: Bandwidth from low nibble of bandwidth register.
// RULE9: New bandwidth applies at next read pulse rise.
// RULE10: Programmed bandwidth overrides pin chosen bandwidth.
// RULE11: Scale bandwidth by two-bit noise select field.
// RULE12: Registers steer imager only when source selects them; output mode, variant bit and noise scale follow registers regardless.
`timescale 1ns/100ps
`default_nettype none
// Offsets, field positions and codes come from the shared constants header.
`include "line_imager_consts.svh"
module line_imager_config_regs (
  // Clock and reset.
  input  wire logic                       clock_in,
  input  wire logic                       arst_n_in,
  // Register access from the slave front end.
  input  wire line_imager_pkg::reg_req_s  req_in,
  output logic                            rvalid_out,
  output logic      [7:0]                 rdata_out,
  output logic                            addr_hit_out,
  // Imager side.
  input  wire logic                       read_pulse_in,
  input  wire line_imager_pkg::pin_cfg_s  pin_cfg_in,
  input  wire logic [12:0]                left_temp_in,
  input  wire logic [12:0]                right_temp_in,
  input  wire logic [7:0]                 bus_error_in,
  input  wire logic [7:0]                 revision_in,
  output line_imager_pkg::imager_cfg_s    cfg_out
);
  import line_imager_pkg::*;

  // ****************************************************************************
  // State
  // ****************************************************************************
  // All flops of this module in one packed struct.
  typedef struct packed {
    logic        rvalid;
    logic        hit;
    logic        read_prev;
    logic [3:0]  bw_applied;
    imager_cfg_s cfg;
  } state_s;

  state_s state_reg;           // Registered state.
  state_s state_next;          // Next state.
  logic [3:0] wslot;           // Slot of the addressed register.
  logic       wslot_ok;        // Address decodes to a listed register.
  logic [7:0] store [0:13];    // Register contents.
  logic [7:0] ext   [0:13];    // Read only inputs per slot.
  logic [7:0] rdata;           // Registered read data from the bank.

  // ****************************************************************************
  // Address decode
  // ****************************************************************************
  // Map the byte address onto one of the fourteen slots.
  always_comb begin
    wslot_ok = 1'b1;
    case (req_in.addr)
      `OFS_IMAGER_CONTROL:   wslot = 4'h0; // see RULE1
      `OFS_VIDEO_BANDWIDTH:  wslot = 4'h1;
      `OFS_MISC_SETTINGS:    wslot = 4'h2;
      `OFS_OSC_FINE_TRIM:    wslot = 4'h3;
      `OFS_BW_NOISE_SELECT:  wslot = 4'h4;
      `OFS_LEFT_TEMP_LOW:    wslot = 4'h5;
      `OFS_LEFT_TEMP_HIGH:   wslot = 4'h6;
      `OFS_RIGHT_TEMP_LOW:   wslot = 4'h7;
      `OFS_RIGHT_TEMP_HIGH:  wslot = 4'h8;
      `OFS_TEMP_SETUP:       wslot = 4'h9;
      `OFS_BUS_ERROR_FLAG:   wslot = 4'hA;
      `OFS_ANALOG_OVERRIDE:  wslot = 4'hB;
      `OFS_OSC_COARSE_TRIM:  wslot = 4'hC;
      `OFS_SILICON_REVISION: wslot = 4'hD;
      default: begin
        // Stray addresses are dropped; no slot is touched.
        wslot    = 4'hF;
        wslot_ok = 1'b0;
      end
    endcase
  end

  // Read only values presented per slot; writable slots carry zero.
  always_comb begin
    for (int i = 0; i < `NUM_REGS; i++) begin
      ext[i] = 8'h00;
    end
    ext[5]  = left_temp_in[7:0];
    ext[6]  = {3'h0, left_temp_in[12:8]};
    ext[7]  = right_temp_in[7:0];
    ext[8]  = {3'h0, right_temp_in[12:8]};
    ext[10] = bus_error_in;
    ext[13] = revision_in;
  end

  // ****************************************************************************
  // Storage
  // ****************************************************************************
  line_imager_bank u_bank (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .we_in     (req_in.wr && wslot_ok),
    .wslot_in  (wslot),
    .wdata_in  (req_in.wdata),
    .rslot_in  (wslot),
    .ext_in    (ext),
    .rdata_out (rdata),
    .store_out (store)
  );

  // ****************************************************************************
  // Effective configuration
  // ****************************************************************************
  // Choose register or pin settings and retime bandwidth on the read pulse.
  always_comb begin
    state_next           = state_reg;
    state_next.rvalid    = req_in.rd;
    state_next.hit       = req_in.rd && wslot_ok;
    state_next.read_prev = read_pulse_in;
    // Bandwidth code is latched only on a rising read pulse edge.
    if (read_pulse_in && !state_reg.read_prev) begin
      state_next.bw_applied = store[1][3:0]; // see RULE9, RULE8
    end
    // Output mode and variant bit always follow the register.
    state_next.cfg.output_mode_field   = store[0][`MODE_LSB+:2];
    state_next.cfg.variant_readout_bit = store[0][`BIT_VARIANT_READOUT];
    state_next.cfg.bandwidth_scale_select = store[4][1:0]; // see RULE11
    if (store[2][`BIT_CONFIG_SOURCE]) begin // see RULE12
      // Register values steer the imager.
      state_next.cfg.gain_code      = store[0][`GAIN_LSB+:2]; // see RULE5
      state_next.cfg.read_direction = store[0][`BIT_READ_DIRECTION]; // see RULE6
      state_next.cfg.bandwidth_code = state_reg.bw_applied; // see RULE10
    end else begin
      // Pins steer the imager.
      state_next.cfg.gain_code      = pin_cfg_in.gain_code;
      state_next.cfg.read_direction = pin_cfg_in.read_direction;
      state_next.cfg.bandwidth_code = pin_cfg_in.bandwidth_code;
    end
  end

  // State register with factory reset values.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg                            <= '0; // see RULE3
      state_reg.bw_applied                 <= `BW_CODE_16MHZ;
      state_reg.cfg.gain_code              <= `GAIN_CODE_ONE;
      state_reg.cfg.output_mode_field      <= 2'h1;
      state_reg.cfg.bandwidth_code         <= `BW_CODE_16MHZ;
      state_reg.cfg.bandwidth_scale_select <= 2'h3;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops.
  assign rvalid_out   = state_reg.rvalid;
  assign addr_hit_out = state_reg.hit;
  assign rdata_out    = rdata;
  assign cfg_out      = state_reg.cfg;
endmodule : line_imager_config_regs
`default_nettype wire

//--- testbench/line_imager_config_regs_checker.sv
/* Port checker for the configuration register bank.
   Assumes it is bound to line_imager_config_regs. */
`timescale 1ns/100ps
`default_nettype none
module line_imager_config_regs_checker (
  // Clock and reset.
  input wire logic                        clock_in,
  input wire logic                        arst_n_in,
  // Watched ports.
  input wire line_imager_pkg::reg_req_s   req_in,
  input wire logic                        rvalid_out,
  input wire logic [7:0]                  rdata_out,
  input wire logic                        addr_hit_out,
  input wire logic                        read_pulse_in,
  input wire line_imager_pkg::pin_cfg_s   pin_cfg_in,
  input wire logic [7:0]                  revision_in,
  input wire line_imager_pkg::imager_cfg_s cfg_out
);
  import line_imager_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  rd_answer_a: assert property (req_in.rd |=> rvalid_out) else $error("read unanswered");
  no_spur_a: assert property (!req_in.rd |=> !rvalid_out) else $error("stray answer");
  hit_ctl_a: assert property (req_in.rd && req_in.addr == 8'h00 |=> addr_hit_out)
    else $error("listed address missed");
  miss_zero_a: assert property (req_in.rd && req_in.addr == 8'h03 |=> !addr_hit_out && rdata_out == 8'h00)
    else $error("unlisted address hit");
  rev_read_a: assert property (req_in.rd && req_in.addr == 8'hFF |=> rdata_out == $past(revision_in))
    else $error("revision wrong");
  scale_follow_a: assert property (req_in.wr && req_in.addr == 8'h94 ##1 !req_in.wr [*2]
    |=> cfg_out.bandwidth_scale_select == $past(req_in.wdata[1:0], 3)) else $error("scale not applied");
  mode_follow_a: assert property (req_in.wr && req_in.addr == 8'h00 ##1 !req_in.wr [*2]
    |=> cfg_out.output_mode_field == $past(req_in.wdata[5:4], 3)) else $error("mode not applied");
  bw_hold_a: assert property ((req_in.wr && req_in.addr == 8'h01 && !read_pulse_in) ##1
    (!read_pulse_in && $stable(pin_cfg_in)) ##1 $stable(pin_cfg_in) |-> $stable(cfg_out.bandwidth_code))
    else $error("bandwidth applied early");
  reset_cfg_a: assert property (!$past(arst_n_in) |-> cfg_out == {2'h1, 2'h1, 2'h0, 4'h5, 2'h3})
    else $error("reset settings wrong");
endmodule : line_imager_config_regs_checker
`default_nettype wire

//--- testbench/line_imager_master.sv
/* Bus master model issuing register requests.
   Assumes one bench process calls its tasks. */
`timescale 1ns/100ps
`default_nettype none
module line_imager_master (
  // Clock.
  input  wire logic                    clock_in,
  // Requests towards the bank.
  output var line_imager_pkg::reg_req_s req_out
);
  import line_imager_pkg::*;
  // Listed addresses, the only places ever written.
  logic [7:0] listed [14] = '{8'h00, 8'h01, 8'h02, 8'h90, 8'h94, 8'hA0, 8'hA1,
                              8'hA2, 8'hA3, 8'hA4, 8'hB0, 8'hD6, 8'hD7, 8'hFF};
  initial req_out = '0;
  // One write, held until its taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a inside {listed}) begin
      @(posedge clock_in);
      req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock_in);
      req_out.wr <= 1'b0;
    end
  endtask : wr
  // One read, held until its taking edge.
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_in);
    req_out.rd <= 1'b0;
  endtask : rd
endmodule : line_imager_master
`default_nettype wire

//--- testbench/test_line_imager_config_regs.sv
/* Self-checking bench for the configuration register bank.
   Assumes the package, design, master model and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module test_line_imager_config_regs;
  import line_imager_pkg::*;
  // ****************
  // Signals
  // ****************
  logic        clock_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        read_pulse_in = 1'b0;
  reg_req_s    req;
  pin_cfg_s    pin_cfg_in = {2'h1, 1'b0, 4'h5};
  logic [12:0] left_temp_in = 13'h1ABC;
  logic [12:0] right_temp_in = 13'h0123;
  logic [7:0]  bus_error_in = 8'h5A;
  logic [7:0]  revision_in = 8'h3C;  // Arbitrary value.
  logic        rvalid_out, addr_hit_out;
  logic [7:0]  rdata_out;
  imager_cfg_s cfg_out;
  int          n_errors = 0, checks_done = 0;
  logic [8:0]  expq [$], exp_rd;
  logic [3:0]  bw_exp = 4'h5;
  logic [7:0]  adr [8] = '{8'h00, 8'h01, 8'h02, 8'h90, 8'h94, 8'hA4, 8'hD6, 8'hD7};
  logic [7:0]  rst [8] = '{8'h14, 8'h05, 8'h98, 8'h00, 8'h03, 8'h00, 8'h20, 8'h00};
  logic [7:0]  msk [8] = '{8'h3F, 8'h0F, 8'h07, 8'h0F, 8'h03, 8'hFF, 8'h0F, 8'h01};
  logic [7:0]  shd [8];
  logic [3:0]  bwc [4] = '{4'hA, 4'h8, 4'h2, 4'h5};
  always #2.5 clock_in = ~clock_in;
  line_imager_master u_line_imager_master (.clock_in(clock_in), .req_out(req));
  line_imager_config_regs u_line_imager_config_regs (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .req_in(req), .rvalid_out(rvalid_out), .rdata_out(rdata_out), .addr_hit_out(addr_hit_out),
    .read_pulse_in(read_pulse_in), .pin_cfg_in(pin_cfg_in), .left_temp_in(left_temp_in),
    .right_temp_in(right_temp_in), .bus_error_in(bus_error_in), .revision_in(revision_in),
    .cfg_out(cfg_out));
  // Monitor: each answer is compared with the oldest note.
  always @(posedge clock_in) begin
    if (rvalid_out === 1'b1) begin
      exp_rd = (expq.size() > 0) ? expq.pop_front() : 9'h1XX;
      `CHK({addr_hit_out, rdata_out}, exp_rd)
    end
  end
  // Notes the expected answer, then issues the read.
  task automatic rd_chk(input logic [7:0] a, input logic [8:0] e);
    expq.push_back(e);
    u_line_imager_master.rd(a);
  endtask : rd_chk
  // Expected settings from shadow copies and pins.
  function automatic imager_cfg_s exp_cfg();
    if (shd[2][0]) return {shd[0][5:0], bw_exp, shd[4][1:0]};
    return {shd[0][5:4], pin_cfg_in.gain_code, shd[0][1], pin_cfg_in.read_direction,
            pin_cfg_in.bandwidth_code, shd[4][1:0]};
  endfunction : exp_cfg
  task automatic cfg_chk();
    repeat (3) @(posedge clock_in);
    #1 `CHK(cfg_out, exp_cfg())
  endtask : cfg_chk
  task automatic pulse();
    @(posedge clock_in) read_pulse_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    read_pulse_in <= 1'b0;
  endtask : pulse
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // Watchdog against a hang.
  initial begin
    #100000 n_errors++;
    end_sim();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h65b7));
    foreach (shd[i]) shd[i] = rst[i];
    repeat (8) @(posedge clock_in);
    arst_n_in <= 1'b1;
    foreach (adr[i]) rd_chk(adr[i], {1'b1, shd[i]});
    u_line_imager_master.wr(8'hFF, 8'h00);
    rd_chk(8'h03, 9'h000);
    rd_chk(8'hFF, {1'b1, revision_in});
    rd_chk(8'hA1, {4'h8, left_temp_in[12:8]});
    rd_chk(8'hA2, {1'b1, right_temp_in[7:0]});
    rd_chk(8'hB0, {1'b1, bus_error_in});
    cfg_chk();
    $display("test reset done");
    foreach (adr[i]) begin
      shd[i] = (shd[i] & ~msk[i]) | (8'($urandom) & msk[i]);
      if (i == 0) shd[0][5:4] = 2'b10;
      u_line_imager_master.wr(adr[i], shd[i]);
    end
    foreach (adr[i]) rd_chk(adr[i], {1'b1, shd[i]});
    $display("test round trip done");
    shd[2][0] = 1'b1;
    u_line_imager_master.wr(8'h02, shd[2]);
    for (int g = 0; g < 6; g++) begin
      shd[0] = {4'b0010, 2'(g / 2), 1'b0, 1'(g)};
      u_line_imager_master.wr(8'h00, shd[0]);
      cfg_chk();
    end
    for (int k = 0; k < 4; k++) begin
      shd[1] = {4'h0, bwc[k]};
      shd[4] = {6'h00, 2'(k)};
      u_line_imager_master.wr(8'h01, shd[1]);
      u_line_imager_master.wr(8'h94, shd[4]);
      cfg_chk();
      pulse();
      bw_exp = bwc[k];
      cfg_chk();
    end
    $display("test register mode done");
    shd[2][0] = 1'b0;
    @(posedge clock_in) pin_cfg_in <= 7'($urandom);
    u_line_imager_master.wr(8'h02, shd[2]);
    pulse();
    cfg_chk();
    $display("test pin mode done");
    @(posedge clock_in) pin_cfg_in <= {2'h1, 1'b0, 4'h5};
    repeat (2) @(posedge clock_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    arst_n_in <= 1'b1;
    foreach (shd[i]) shd[i] = rst[i];
    bw_exp = 4'h5;
    foreach (adr[i]) rd_chk(adr[i], {1'b1, shd[i]});
    cfg_chk();
    repeat (3) @(posedge clock_in);
    $display("test second reset done");
    end_sim();
  end
endmodule : test_line_imager_config_regs
bind line_imager_config_regs line_imager_config_regs_checker u_line_imager_config_regs_checker (
  .clock_in, .arst_n_in, .req_in, .rvalid_out, .rdata_out, .addr_hit_out, .read_pulse_in,
  .pin_cfg_in, .revision_in, .cfg_out);
`default_nettype wire
